// file: src/risc_core_pkg.sv
// Shared constants, encodings and types of the 8-bit core datapath
package risc_core_pkg;

   // Widths of the two independent buses
   localparam int unsigned IW = 14;
   localparam int unsigned PC_W = 12;
   localparam int unsigned DW = 8;
   localparam int unsigned DA_W = 8;
   localparam int unsigned FA_W = 7;

   // Instruction fields: class, function, destination, file address, literal
   localparam int unsigned CLS_HI = 13;
   localparam int unsigned CLS_LO = 12;
   localparam int unsigned FN_HI = 11;
   localparam int unsigned FN_LO = 8;
   localparam int unsigned DEST_BIT = 7;

   localparam logic [1:0] CLS_BYTE = 2'h0;
   localparam logic [1:0] CLS_JZ = 2'h1;
   localparam logic [1:0] CLS_JMP = 2'h2;
   localparam logic [1:0] CLS_LIT = 2'h3;

   // Special registers mapped into the data space, mirrored in every bank
   localparam logic [FA_W-1:0] ADDR_IND = 7'h00;
   localparam logic [FA_W-1:0] ADDR_PCL = 7'h02;
   localparam logic [FA_W-1:0] ADDR_STAT = 7'h03;
   localparam logic [FA_W-1:0] ADDR_PTR = 7'h04;

   // Status layout
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_NIB = 1;
   localparam int unsigned FLAG_Z = 2;
   localparam int unsigned STAT_BANK = 5;

   // Reset values
   localparam logic [PC_W-1:0] PC_RST = 12'h000;
   localparam logic [DW-1:0] W_RST = 8'h00;
   localparam logic [DW-1:0] STAT_RST = 8'h00;
   localparam logic [DW-1:0] PTR_RST = 8'h00;
   localparam logic [IW-1:0] IR_RST = 14'h0000;

   // Four clock periods per instruction cycle
   typedef enum logic [1:0] {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b10,
      PH_Q4 = 2'b11
   } phase_t;

   typedef enum logic [3:0] {
      OP_MOV = 4'h0,
      OP_ADD = 4'h1,
      OP_SUB = 4'h2,
      OP_AND = 4'h3,
      OP_IOR = 4'h4,
      OP_XOR = 4'h5,
      OP_COM = 4'h6,
      OP_INC = 4'h7,
      OP_DEC = 4'h8,
      OP_RRF = 4'h9,
      OP_RLF = 4'ha,
      OP_CLR = 4'hb,
      OP_SWAP = 4'hc,
      OP_MOVWF = 4'hd
   } alu_op_t;

endpackage

// file: src/risc_core_alu_datapath.sv
// Core datapath: fetch/execute pipeline, 8-bit ALU, accumulator and status
//
// Summary of operation
// - Program and data memories have separate buses used in the same cycle.
// - Each instruction is one 14-bit word fetched in one instruction cycle.
// - Next instruction is fetched while the current one executes.
// - Every non-branching instruction completes in exactly one instruction cycle.
// - Taken branches cost two cycles: prefetched word discarded, pipeline refilled.
// - An instruction cycle is four clocks; cycle-rate output toggles at that rate.
// - Data space is reached by direct address or through the pointer register.
// - Special registers, program counter low byte included, sit in data space.
// - Every operation works on any register in any addressing mode.
// - ALU is 8 bits: add, subtract, shifts and logic operations.
// - Arithmetic is two's complement.
// - Two-operand ops use accumulator and a file register or literal.
// - Single-operand ops use a file register or literal; result goes to accumulator or file register.
// - Accumulator is 8 bits and has no data-space address.
// - ALU updates carry, nibble carry and zero flags in status.
// - In subtraction carry and nibble carry act as borrow indications.
`timescale 1ns/100ps
`default_nettype none

module risc_core_alu_datapath
   import risc_core_pkg::*;
(
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic cycle_out_en_i,
   output logic [PC_W-1:0] prog_addr_o,
   input wire logic [IW-1:0] prog_data_i,
   output logic [DA_W-1:0] data_addr_o,
   input wire logic [DW-1:0] data_rdata_i,
   output logic [DW-1:0] data_wdata_o,
   output logic data_we_o,
   output logic cycle_rate_output_o
);

   phase_t phase, next_phase;
   logic [IW-1:0] ir;
   logic ir_valid;
   logic [DW-1:0] w, ptr, stat, opnd, res;
   logic res_c, res_nib, res_z;
   logic [DW-1:0] a_res;
   logic a_c, a_nib, a_z;
   logic [DW-1:0] next_stat;

   ////////////////////////////////////////////////////////////////////////
   // Decode
   wire [1:0] cls = ir[CLS_HI:CLS_LO];
   wire alu_op_t func = alu_op_t'(ir[FN_HI:FN_LO]);
   wire dest_f = ir[DEST_BIT];
   wire [FA_W-1:0] fld = ir[FA_W-1:0];
   wire [DW-1:0] lit = ir[DW-1:0];
   wire is_byte = ir_valid && (cls == CLS_BYTE);
   wire is_lit = ir_valid && (cls == CLS_LIT);
   wire is_jmp = ir_valid && (cls == CLS_JMP);
   wire is_jz = ir_valid && (cls == CLS_JZ);
   wire wr_f = is_byte && dest_f;
   wire wr_w = is_lit || (is_byte && !dest_f);

   wire indirect = (fld == ADDR_IND);
   wire [DA_W-1:0] eff_addr = indirect ? ptr : {stat[STAT_BANK], fld};

   // special registers decoded on the latched address
   wire [FA_W-1:0] low_addr = data_addr_o[FA_W-1:0];
   wire hit_ind = (low_addr == ADDR_IND);
   wire hit_pcl = (low_addr == ADDR_PCL);
   wire hit_stat = (low_addr == ADDR_STAT);
   wire hit_ptr = (low_addr == ADDR_PTR);
   wire hit_sfr = hit_ind || hit_pcl || hit_stat || hit_ptr;
   wire [DW-1:0] rd_val = hit_pcl ? prog_addr_o[DW-1:0] :
                          hit_stat ? stat :
                          hit_ptr ? ptr :
                          hit_ind ? '0 : data_rdata_i;

   // taken branch or write to the program counter low byte
   wire in_q4 = (phase == PH_Q4);
   wire pcl_write = wr_f && hit_pcl;
   wire branch_take = in_q4 && (is_jmp || (is_jz && stat[FLAG_Z]) || pcl_write);
   wire [PC_W-1:0] target = pcl_write ? {prog_addr_o[PC_W-1:DW], res} : ir[PC_W-1:0];

   ////////////////////////////////////////////////////////////////////////
   // ALU
   // subtraction adds the inverted accumulator plus one
   wire is_sub = (func == OP_SUB);
   wire [DW-1:0] b_op = is_sub ? ~w : w;
   wire [DW:0] sum9 = {1'b0, opnd} + {1'b0, b_op} + {{DW{1'b0}}, is_sub};
   wire [4:0] nib5 = {1'b0, opnd[3:0]} + {1'b0, b_op[3:0]} + {4'h0, is_sub};

   always_comb begin
      logic upd_z;
      upd_z = 1'b1;
      a_res = opnd;
      a_c = stat[FLAG_C];
      a_nib = stat[FLAG_NIB];
      case (func)
         OP_ADD, OP_SUB: begin
            a_res = sum9[DW-1:0];
            a_c = sum9[DW];
            a_nib = nib5[4];
         end
         OP_AND: a_res = opnd & w;
         OP_IOR: a_res = opnd | w;
         OP_XOR: a_res = opnd ^ w;
         OP_COM: a_res = ~opnd;
         OP_INC: a_res = opnd + 8'h01;
         OP_DEC: a_res = opnd - 8'h01;
         OP_RRF: begin
            a_res = {stat[FLAG_C], opnd[DW-1:1]};
            a_c = opnd[0];
            upd_z = 1'b0;
         end
         OP_RLF: begin
            a_res = {opnd[DW-2:0], stat[FLAG_C]};
            a_c = opnd[DW-1];
            upd_z = 1'b0;
         end
         OP_CLR: a_res = '0;
         OP_SWAP: begin
            a_res = {opnd[3:0], opnd[DW-1:4]};
            upd_z = 1'b0;
         end
         OP_MOVWF: begin
            a_res = w;
            upd_z = 1'b0;
         end
         default: a_res = opnd;
      endcase
      // zero flag follows the result where the operation affects it
      a_z = upd_z ? (a_res == '0) : stat[FLAG_Z];
   end

   // Status written as data first, then the ALU flags laid over it
   always_comb begin
      next_stat = pcl_write ? stat : ((wr_f && hit_stat) ? res : stat);
      if (is_byte || is_lit) begin
         next_stat[FLAG_C] = res_c;
         next_stat[FLAG_NIB] = res_nib;
         next_stat[FLAG_Z] = res_z;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Phase sequencer
   // four clocks per instruction cycle
   always_comb begin
      case (phase)
         PH_Q1: next_phase = PH_Q2;
         PH_Q2: next_phase = PH_Q3;
         PH_Q3: next_phase = PH_Q4;
         default: next_phase = PH_Q1;
      endcase
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         phase <= PH_Q1;
         cycle_rate_output_o <= 1'b0;
      end else begin
         phase <= next_phase;
         // high in Q1 and Q2, low in Q3 and Q4
         cycle_rate_output_o <= cycle_out_en_i && (next_phase == PH_Q1 || next_phase == PH_Q2);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fetch stage
   // the word at the counter is latched while the current one finishes
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prog_addr_o <= PC_RST;
         ir <= IR_RST;
         ir_valid <= 1'b0;
      end else if (in_q4) begin
         // one whole word per instruction cycle
         ir <= prog_data_i;
         // discard the prefetched word on a taken branch
         ir_valid <= !branch_take;
         prog_addr_o <= branch_take ? target : prog_addr_o + 12'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Execute stage: Q1 address, Q2 read, Q3 compute, Q4 write back
   // data access runs on its own bus alongside the fetch
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_addr_o <= '0;
         opnd <= '0;
      end else begin
         if (phase == PH_Q1) begin
            data_addr_o <= eff_addr;
         end
         // second operand is a file register or the literal
         if (phase == PH_Q2) begin
            opnd <= is_lit ? lit : rd_val;
         end
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         res <= '0;
         res_c <= 1'b0;
         res_nib <= 1'b0;
         res_z <= 1'b0;
         data_wdata_o <= '0;
         data_we_o <= 1'b0;
      end else begin
         if (phase == PH_Q3) begin
            res <= a_res;
            res_c <= a_c;
            res_nib <= a_nib;
            res_z <= a_z;
            data_wdata_o <= a_res;
         end
         // any file address may be a destination; special ones stay inside
         data_we_o <= (phase == PH_Q3) && wr_f && !hit_sfr;
      end
   end

   // all results commit at the end of the same instruction cycle
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         w <= W_RST;
         ptr <= PTR_RST;
         stat <= STAT_RST;
      end else if (in_q4) begin
         // result goes to accumulator or file register
         if (wr_w) begin
            w <= res;
         end
         if (wr_f && hit_ptr) begin
            ptr <= res;
         end
         stat <= next_stat;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);

   a_phase_wrap: assert property (phase == PH_Q4 |=> phase == PH_Q1 ##1 phase == PH_Q2)
      else $error("phase sequence broken");

   // The rise right after reset lands in Q2, so only rises in Q1 start a check
   a_cycle_rate_output_rate: assert property (cycle_out_en_i [*5] ##0 ($rose(cycle_rate_output_o) && phase == PH_Q1)
      |-> cycle_rate_output_o [*2] ##1 !cycle_rate_output_o [*2] ##1 cycle_rate_output_o)
      else $error("cycle rate output not four clocks");

   a_fetch_step: assert property (in_q4 && !branch_take
      |=> prog_addr_o == $past(prog_addr_o) + 12'h001 && ir == $past(prog_data_i))
      else $error("sequential fetch wrong");

   a_branch_flush: assert property (branch_take
      |=> !ir_valid && prog_addr_o == $past(target) ##4 ir_valid)
      else $error("branch did not refill pipeline");

   a_word_per_cycle: assert property ($changed(prog_addr_o) |-> $past(phase) == PH_Q4)
      else $error("fetch outside instruction cycle end");

   a_accum_commit: assert property ($changed(w) |-> $past(phase) == PH_Q4 && $past(wr_w))
      else $error("accumulator changed without a write");

   a_write_slot: assert property (data_we_o
      |-> phase == PH_Q4 && data_wdata_o == res && !hit_sfr)
      else $error("data write outside Q4");

   a_add_flags: assert property (phase == PH_Q3 && func == OP_ADD
      |=> {res_c, res} == $past({1'b0, opnd} + {1'b0, w}) && res_z == (res == '0))
      else $error("add result or flags wrong");

   a_add_nibble: assert property (phase == PH_Q3 && func == OP_ADD
      |=> res_nib == ({1'b0, $past(opnd[3:0])} + {1'b0, $past(w[3:0])} > 5'h0f))
      else $error("nibble carry of add wrong");

   a_sub_result: assert property (phase == PH_Q3 && func == OP_SUB
      |=> res == $past(opnd - w))
      else $error("subtract result wrong");

   a_sub_borrow: assert property (phase == PH_Q3 && func == OP_SUB
      |=> res_c == ($past(opnd) >= $past(w)) && res_nib == ($past(opnd[3:0]) >= $past(w[3:0])))
      else $error("subtract borrow wrong");

   a_flag_commit: assert property (in_q4 && is_byte && !hit_stat
      |=> stat[FLAG_C] == $past(res_c) && stat[FLAG_Z] == $past(res_z))
      else $error("status flags not committed");

   c_branch_taken: cover property (branch_take && is_jz);
   c_pcl_jump: cover property (branch_take && pcl_write);
   c_add_carry: cover property (phase == PH_Q3 && func == OP_ADD && a_c);
   c_sub_borrow: cover property (phase == PH_Q3 && func == OP_SUB && !a_c);
   c_indirect: cover property (phase == PH_Q1 && is_byte && indirect);

endmodule

`default_nettype wire

// file: testbench/core_mem_model.sv
// Program and data memories that sit around the core datapath
`timescale 1ns/100ps
`default_nettype none

module core_mem_model
   import risc_core_pkg::*;
(
   input wire logic clock_i,
   input wire logic [PC_W-1:0] prog_addr_i,
   output logic [IW-1:0] prog_data_o,
   input wire logic [DA_W-1:0] data_addr_i,
   output logic [DW-1:0] data_rdata_o,
   input wire logic [DW-1:0] data_wdata_i,
   input wire logic data_we_i
);
   logic [IW-1:0] rom [0:(1<<PC_W)-1];
   logic [DW-1:0] ram [0:(1<<DA_W)-1];

   ////////////////////////////////////////////////////////////////
   // separate independent buses
   // Reads are combinational so a fetch and a data read overlap freely
   assign prog_data_o = rom[prog_addr_i];
   assign data_rdata_o = ram[data_addr_i];

   always @(posedge clock_i) begin
      if (data_we_i === 1'b1) begin
         ram[data_addr_i] <= data_wdata_i;
      end
   end
endmodule

`default_nettype wire

// file: testbench/risc_core_alu_datapath_tb.sv
// Self-checking bench for the core datapath with its two memories
`timescale 1ns/100ps
`default_nettype none

module risc_core_alu_datapath_tb;
   import risc_core_pkg::*;

   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic cycle_out_en = 1'b0;
   logic [PC_W-1:0] prog_addr;
   logic [IW-1:0] prog_data;
   logic [DA_W-1:0] data_addr;
   logic [DW-1:0] data_rdata;
   logic [DW-1:0] data_wdata;
   logic data_we;
   logic cycle_rate;
   int err_total = 0;
   int n_tests = 0;

   always #5 clock = ~clock;

   risc_core_alu_datapath i_risc_core_alu_datapath (
      .clock_i(clock), .resetn_i(resetn), .cycle_out_en_i(cycle_out_en),
      .prog_addr_o(prog_addr), .prog_data_i(prog_data), .data_addr_o(data_addr),
      .data_rdata_i(data_rdata), .data_wdata_o(data_wdata), .data_we_o(data_we),
      .cycle_rate_output_o(cycle_rate)
   );

   core_mem_model i_core_mem_model (
      .clock_i(clock), .prog_addr_i(prog_addr), .prog_data_o(prog_data),
      .data_addr_i(data_addr), .data_rdata_o(data_rdata), .data_wdata_i(data_wdata),
      .data_we_i(data_we)
   );

   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Core is held in reset while memories are rewritten, so no write races
   task automatic prep();
      resetn = 1'b0;
      @(negedge clock);
      for (int i = 0; i < 16; i++) begin
         i_core_mem_model.rom[i] = 14'h3000;
      end
      for (int i = 0; i < 256; i++) begin
         i_core_mem_model.ram[i] = 8'h00;
      end
   endtask

   task automatic run(input int n);
      repeat (4) @(negedge clock);
      resetn = 1'b1;
      repeat (n) @(negedge clock);
   endtask

   ////////////////////////////////////////////////////////////////
   task automatic arith(input alu_op_t op, input logic [7:0] w0, lit, res, stat);
      prep();
      i_core_mem_model.rom[0] = {2'b11, 4'h0, w0};
      i_core_mem_model.rom[1] = {2'b11, op, lit};
      i_core_mem_model.rom[2] = 14'h0da0;
      i_core_mem_model.rom[3] = 14'h0003;
      i_core_mem_model.rom[4] = 14'h0da1;
      i_core_mem_model.rom[5] = 14'h2005;
      run(64);
      check({8'h00, i_core_mem_model.ram[8'h20]}, {8'h00, res});
      check({8'h00, i_core_mem_model.ram[8'h21]}, {8'h00, stat});
      $display("arith op=%h done", op);
   endtask

   task automatic timing();
      logic [PC_W-1:0] last;
      logic [3:0] pat;
      int cnt;
      prep();
      cycle_out_en = 1'b1;
      run(0);
      pat = 4'h0;
      for (int k = 0; k < 6; k++) begin
         last = prog_addr;
         cnt = 0;
         while (prog_addr === last && cnt < 8) begin
            @(negedge clock);
            cnt++;
            pat = {pat[2:0], cycle_rate};
         end
         check({4'h0, prog_addr}, {4'h0, last + 12'h001});
         if (k > 0) begin
            check(16'(cnt), 16'h0004);
            check({12'h000, pat}, 16'h0009);
         end
      end
      cycle_out_en = 1'b0;
      repeat (2) @(negedge clock);
      for (int k = 0; k < 4; k++) begin
         check({15'h0000, cycle_rate}, 16'h0000);
         @(negedge clock);
      end
      $display("timing done");
   endtask

   // Skipped words write a value that would overwrite the preset byte
   task automatic branch();
      prep();
      i_core_mem_model.ram[8'h22] = 8'h99;
      i_core_mem_model.rom[0] = 14'h3011;
      i_core_mem_model.rom[1] = 14'h1003;
      i_core_mem_model.rom[2] = 14'h0da4;
      i_core_mem_model.rom[3] = 14'h2005;
      i_core_mem_model.rom[4] = 14'h0da2;
      i_core_mem_model.rom[5] = 14'h0da3;
      i_core_mem_model.rom[6] = 14'h3300;
      i_core_mem_model.rom[7] = 14'h1009;
      i_core_mem_model.rom[8] = 14'h0da2;
      i_core_mem_model.rom[9] = 14'h2009;
      run(80);
      check({8'h00, i_core_mem_model.ram[8'h22]}, 16'h0099);
      check({8'h00, i_core_mem_model.ram[8'h23]}, 16'h0011);
      check({8'h00, i_core_mem_model.ram[8'h24]}, 16'h0011);
      $display("branch done");
   endtask

   task automatic indirect();
      prep();
      i_core_mem_model.ram[8'h04] = 8'hee;
      i_core_mem_model.ram[8'h25] = 8'hff;
      i_core_mem_model.rom[0] = 14'h3030;
      i_core_mem_model.rom[1] = 14'h0d84;
      i_core_mem_model.rom[2] = 14'h305a;
      i_core_mem_model.rom[3] = 14'h0d80;
      i_core_mem_model.rom[4] = 14'h07a5;
      i_core_mem_model.rom[5] = 14'h3009;
      i_core_mem_model.rom[6] = 14'h0d82;
      i_core_mem_model.rom[7] = 14'h0da5;
      i_core_mem_model.rom[9] = 14'h0da6;
      i_core_mem_model.rom[10] = 14'h200a;
      run(80);
      check({8'h00, i_core_mem_model.ram[8'h30]}, 16'h005a);
      check({8'h00, i_core_mem_model.ram[8'h04]}, 16'h00ee);
      check({8'h00, i_core_mem_model.ram[8'h25]}, 16'h0000);
      check({8'h00, i_core_mem_model.ram[8'h26]}, 16'h0009);
      $display("indirect done");
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      arith(OP_ADD, 8'hff, 8'h01, 8'h00, 8'h07);
      arith(OP_ADD, 8'h08, 8'h08, 8'h10, 8'h02);
      arith(OP_SUB, 8'h06, 8'h05, 8'hff, 8'h00);
      arith(OP_SUB, 8'h01, 8'h10, 8'h0f, 8'h01);
      arith(OP_SUB, 8'h05, 8'h05, 8'h00, 8'h07);
      arith(OP_AND, 8'hf0, 8'h0f, 8'h00, 8'h04);
      arith(OP_IOR, 8'hf0, 8'h0f, 8'hff, 8'h00);
      arith(OP_XOR, 8'hff, 8'hff, 8'h00, 8'h04);
      arith(OP_COM, 8'h00, 8'h5a, 8'ha5, 8'h00);
      arith(OP_INC, 8'h11, 8'hff, 8'h00, 8'h04);
      arith(OP_DEC, 8'h00, 8'h00, 8'hff, 8'h00);
      arith(OP_RRF, 8'h00, 8'h81, 8'h40, 8'h05);
      arith(OP_RLF, 8'h01, 8'h81, 8'h02, 8'h01);
      arith(OP_CLR, 8'h33, 8'h77, 8'h00, 8'h04);
      arith(OP_SWAP, 8'h00, 8'h3c, 8'hc3, 8'h04);
      timing();
      branch();
      indirect();
      wrap_up();
   end

   // Whole run is about 1240 clocks, so this limit only catches a hang
   initial begin
      #100000;
      err_total++;
      wrap_up();
   end
endmodule

`default_nettype wire
